// >>> hw/exec_pkg.sv
package exec_pkg;

  // ----------------------------------------------------------------
  // operation codes presented by the decoder
  // ----------------------------------------------------------------
  typedef enum logic [3:0]
  {
    OP_NONE      = 4'h0,
    OP_SWAP_WORK = 4'h1,
    OP_SKIP_ZERO = 4'h2,
    OP_LOAD_SKIP = 4'h3,
    OP_BIT_SKIP  = 4'h4,
    OP_ROM_CUR   = 4'h5,
    OP_ROM_LAST  = 4'h6,
    OP_XOR_WORK  = 4'h7,
    OP_XOR_MEM   = 4'h8,
    OP_XOR_IMM   = 4'h9
  } op_t;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int          ROM_AW       = 12;
  localparam int          ROM_DW       = 15;
  localparam int          PAGE_W       = 4;
  localparam int          SKIP_CYCLES  = 2;
  localparam logic [7:0]  WORK_RST     = 8'h00;
  localparam logic [6:0]  HIGH_RST     = 7'h00;
  localparam logic [3:0]  LAST_PAGE    = 4'hf;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic       valid;
    op_t        op;
    logic [2:0] bit_sel;
    logic [7:0] imm;
  } instr_t;

  typedef struct packed
  {
    logic       we;
    logic [7:0] data;
  } mem_wr_t;

endpackage

// >>> hw/xor_unit.sv
`timescale 1ns/10ps
module xor_unit
(
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  output logic      [7:0] result,
  output logic            zero
);

  always_comb
  begin
    result = a ^ b;
    zero   = (result == 8'h00);
  end

endmodule

// >>> hw/skip_swap_exec.sv
`timescale 1ns/10ps
// Behaviour
// [RQ1] swap operand nibbles into working register only
// [RQ2] skip next when memory byte is zero
// [RQ3] skip discards prefetch, adds one dummy cycle
// [RQ4] copy byte to working, skip if zero
// [RQ5] skip next when selected bit is zero
// [RQ6] current page ROM low byte to memory
// [RQ7] last page ROM low byte to memory
// [RQ8] ROM high byte loads table high latch
// [RQ9] xor memory into working, zero flag only
// [RQ10] xor result written back to memory
// [RQ11] xor immediate into working register
// [RQ12] zero flag set when xor result zero
module skip_swap_exec
(
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire exec_pkg::instr_t              instr,
  input  wire logic [7:0]                    mem_rdata,
  input  wire logic [7:0]                    rom_table_pointer,
  input  wire logic [exec_pkg::PAGE_W-1:0]   pc_page,
  input  wire logic [exec_pkg::ROM_DW-1:0]   rom_rdata,
  output logic [7:0]                         working_register,
  output logic [6:0]                         table_high_latch,
  output exec_pkg::mem_wr_t                  mem_wr,
  output logic [exec_pkg::ROM_AW-1:0]        rom_addr,
  output logic                               zero_flag_we,
  output logic                               zero_flag,
  output logic                               flush_prefetch,
  output logic                               dummy_cycle
);

  // ----------------------------------------------------------------
  // combinational decode
  // ----------------------------------------------------------------
  logic [7:0] xor_b;
  logic [7:0] xor_res;
  logic       xor_zero;
  logic       skip;
  logic       is_rom;

  // immediate form uses the instruction constant instead of memory
  assign xor_b  = (instr.op == exec_pkg::OP_XOR_IMM) ? instr.imm : mem_rdata;
  assign is_rom = instr.valid && ((instr.op == exec_pkg::OP_ROM_CUR)
                                 || (instr.op == exec_pkg::OP_ROM_LAST));

  xor_unit u_xor
  (
    .a      (working_register),
    .b      (xor_b),
    .result (xor_res),
    .zero   (xor_zero)
  );

  always_comb
  begin
    skip = 1'b0;
    if (instr.valid && !dummy_cycle)
    begin
      case (instr.op)
        exec_pkg::OP_SKIP_ZERO: skip = (mem_rdata == 8'h00);         // [RQ2]
        exec_pkg::OP_LOAD_SKIP: skip = (mem_rdata == 8'h00);         // [RQ4]
        exec_pkg::OP_BIT_SKIP:  skip = ~mem_rdata[instr.bit_sel];    // [RQ5]
        default:                skip = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // rom address: the rom word is read combinationally this cycle
  // ----------------------------------------------------------------
  logic [exec_pkg::ROM_AW-1:0] nxt_rom_addr;

  always_comb
  begin
    if (instr.op == exec_pkg::OP_ROM_LAST)
      nxt_rom_addr = {exec_pkg::LAST_PAGE, rom_table_pointer};       // [RQ7]
    else
      nxt_rom_addr = {pc_page, rom_table_pointer};                   // [RQ6]
  end

  assign rom_addr = nxt_rom_addr;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [7:0] working_ff;
  logic [7:0] nxt_working;
  logic [6:0] high_ff;
  logic [6:0] nxt_high;
  logic       mem_we_ff;
  logic       nxt_mem_we;
  logic [7:0] mem_data_ff;
  logic [7:0] nxt_mem_data;
  logic       zwe_ff;
  logic       nxt_zwe;
  logic       z_ff;
  logic       nxt_z;
  logic       dummy_ff;
  logic       nxt_dummy;

  always_comb
  begin
    nxt_working  = working_ff;
    nxt_high     = high_ff;
    nxt_mem_we   = 1'b0;
    nxt_mem_data = mem_data_ff;
    nxt_zwe      = 1'b0;
    nxt_z        = z_ff;
    // a skipped instruction sits in the dummy slot and must not execute
    nxt_dummy    = skip;                                             // [RQ3]
    if (instr.valid && !dummy_ff)
    begin
      case (instr.op)
        exec_pkg::OP_SWAP_WORK:
          nxt_working = {mem_rdata[3:0], mem_rdata[7:4]};            // [RQ1]
        exec_pkg::OP_LOAD_SKIP:
          nxt_working = mem_rdata;                                   // [RQ4]
        exec_pkg::OP_ROM_CUR, exec_pkg::OP_ROM_LAST:
        begin
          nxt_mem_we   = 1'b1;                                       // [RQ6] [RQ7]
          nxt_mem_data = rom_rdata[7:0];
          nxt_high     = rom_rdata[exec_pkg::ROM_DW-1:8];            // [RQ8]
        end
        exec_pkg::OP_XOR_WORK, exec_pkg::OP_XOR_IMM:
        begin
          nxt_working = xor_res;                                     // [RQ9] [RQ11]
          nxt_zwe     = 1'b1;
          nxt_z       = xor_zero;                                    // [RQ12]
        end
        exec_pkg::OP_XOR_MEM:
        begin
          nxt_mem_we   = 1'b1;                                       // [RQ10]
          nxt_mem_data = xor_res;
          nxt_zwe      = 1'b1;
          nxt_z        = xor_zero;                                   // [RQ12]
        end
        default:
          nxt_working = working_ff;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      working_ff  <= exec_pkg::WORK_RST;
      high_ff     <= exec_pkg::HIGH_RST;
      mem_we_ff   <= 1'b0;
      mem_data_ff <= 8'h00;
      zwe_ff      <= 1'b0;
      z_ff        <= 1'b0;
      dummy_ff    <= 1'b0;
    end
    else
    begin
      working_ff  <= nxt_working;
      high_ff     <= nxt_high;
      mem_we_ff   <= nxt_mem_we;
      mem_data_ff <= nxt_mem_data;
      zwe_ff      <= nxt_zwe;
      z_ff        <= nxt_z;
      dummy_ff    <= nxt_dummy;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign working_register = working_ff;
  assign table_high_latch = high_ff;
  assign mem_wr.we        = mem_we_ff;
  assign mem_wr.data      = mem_data_ff;
  assign zero_flag_we     = zwe_ff;
  assign zero_flag        = z_ff;
  assign flush_prefetch   = dummy_ff;
  assign dummy_cycle      = dummy_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_swap_nibbles: assert property (@(posedge clk) disable iff (rst)   // [RQ1]
    (instr.valid && !dummy_ff && instr.op == exec_pkg::OP_SWAP_WORK)
    |=> working_register == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])}
        && !zero_flag_we && !mem_wr.we)
    else $error("swap result wrong");

  a_skip_zero: assert property (@(posedge clk) disable iff (rst)      // [RQ2]
    (instr.valid && !dummy_ff && instr.op == exec_pkg::OP_SKIP_ZERO)
    |=> (dummy_cycle == ($past(mem_rdata) == 8'h00)) && !zero_flag_we)
    else $error("byte skip wrong");

  // the discarded prefetch must leave no trace in the working register, the table high latch or any pulse
  a_skip_one_dummy: assert property (@(posedge clk) disable iff (rst) // [RQ3]
    dummy_cycle |=> !dummy_cycle && !mem_wr.we && !zero_flag_we
        && $stable(working_register) && $stable(table_high_latch))
    else $error("discarded slot left a trace");

  a_load_skip: assert property (@(posedge clk) disable iff (rst)      // [RQ4]
    (instr.valid && !dummy_ff && instr.op == exec_pkg::OP_LOAD_SKIP)
    |=> working_register == $past(mem_rdata)
        && dummy_cycle == ($past(mem_rdata) == 8'h00) && !zero_flag_we)
    else $error("load skip wrong");

  a_bit_skip: assert property (@(posedge clk) disable iff (rst)       // [RQ5]
    (instr.valid && !dummy_ff && instr.op == exec_pkg::OP_BIT_SKIP)
    |=> dummy_cycle == !$past(mem_rdata[instr.bit_sel]) && !mem_wr.we)
    else $error("bit skip wrong");

  a_rom_last: assert property (@(posedge clk) disable iff (rst)       // [RQ7]
    (instr.valid && instr.op == exec_pkg::OP_ROM_LAST)
    |-> rom_addr == {exec_pkg::LAST_PAGE, rom_table_pointer})
    else $error("last page address wrong");

  a_rom_bytes: assert property (@(posedge clk) disable iff (rst)      // [RQ8]
    (is_rom && !dummy_ff)
    |=> mem_wr.we && mem_wr.data == $past(rom_rdata[7:0])
        && table_high_latch == $past(rom_rdata[14:8]) && !zero_flag_we)
    else $error("table read bytes wrong");

  a_xor_memory: assert property (@(posedge clk) disable iff (rst)     // [RQ10]
    (instr.valid && !dummy_ff && instr.op == exec_pkg::OP_XOR_MEM)
    |=> mem_wr.we && mem_wr.data == ($past(working_register) ^ $past(mem_rdata))
        && zero_flag_we && zero_flag == (mem_wr.data == 8'h00))
    else $error("xor to memory wrong");

  a_xor_imm: assert property (@(posedge clk) disable iff (rst)        // [RQ11]
    (instr.valid && !dummy_ff && instr.op == exec_pkg::OP_XOR_IMM)
    |=> working_register == ($past(working_register) ^ $past(instr.imm))
        && zero_flag == (working_register == 8'h00))              // [RQ12]
    else $error("xor immediate wrong");

endmodule

// >>> tb/test_skip_swap_exec.sv
`timescale 1ns/10ps
module test_skip_swap_exec;
  logic                clk;
  logic                rst;
  exec_pkg::instr_t    instr;
  logic [7:0]          mem_rdata;
  logic [7:0]          rom_table_pointer;
  logic [3:0]          pc_page;
  logic [14:0]         rom_rdata;
  logic [7:0]          working_register;
  logic [6:0]          table_high_latch;
  exec_pkg::mem_wr_t   mem_wr;
  logic [11:0]         rom_addr;
  logic                zero_flag_we;
  logic                zero_flag;
  logic                flush_prefetch;
  logic                dummy_cycle;
  int                  failures;
  int                  compares;

  skip_swap_exec u_dut
  (
    .clk               (clk),
    .rst               (rst),
    .instr             (instr),
    .mem_rdata         (mem_rdata),
    .rom_table_pointer (rom_table_pointer),
    .pc_page           (pc_page),
    .rom_rdata         (rom_rdata),
    .working_register  (working_register),
    .table_high_latch  (table_high_latch),
    .mem_wr            (mem_wr),
    .rom_addr          (rom_addr),
    .zero_flag_we      (zero_flag_we),
    .zero_flag         (zero_flag),
    .flush_prefetch    (flush_prefetch),
    .dummy_cycle       (dummy_cycle)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // pulse outputs: memory write, flag write, flush, dummy
  task automatic outs(input logic we, input logic zwe, input logic d);
    chk({mem_wr.we, zero_flag_we, flush_prefetch, dummy_cycle}, {we, zwe, d, d});
  endtask

  // the instruction stays presented until the next issue replaces it, so
  // back-to-back issues never assign instr twice in one time step
  task automatic issue(input exec_pkg::op_t op, input logic [2:0] bs,
                       input logic [7:0] imm, input logic [7:0] m);
    instr = '{valid: 1'b1, op: op, bit_sel: bs, imm: imm};
    mem_rdata = m;
    #1;
    if (op == exec_pkg::OP_ROM_CUR)
      chk(rom_addr, {pc_page, rom_table_pointer});
    if (op == exec_pkg::OP_ROM_LAST)
      chk(rom_addr, {exec_pkg::LAST_PAGE, rom_table_pointer});
    @(negedge clk);
  endtask

  task automatic close_out();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_swap();
    issue(exec_pkg::OP_LOAD_SKIP, 3'h0, 8'h00, 8'h96);
    issue(exec_pkg::OP_SWAP_WORK, 3'h0, 8'h00, 8'h3c);
    chk(working_register, 8'hc3);
    outs(1'b0, 1'b0, 1'b0);
    $display("swap done");
  endtask

  // each skip form taken and not taken; the instruction after a taken
  // skip is the discarded prefetch and must leave no trace
  task automatic t_skip();
    exec_pkg::op_t ops [6];
    logic [7:0]    ms  [6];
    logic          sk;
    logic [7:0]    w;
    ops = '{exec_pkg::OP_SKIP_ZERO, exec_pkg::OP_SKIP_ZERO, exec_pkg::OP_LOAD_SKIP,
            exec_pkg::OP_LOAD_SKIP, exec_pkg::OP_BIT_SKIP, exec_pkg::OP_BIT_SKIP};
    ms  = '{8'h00, 8'h01, 8'h00, 8'h80, 8'hf7, 8'h08};
    for (int i = 0; i < 6; i++)
    begin
      issue(exec_pkg::OP_LOAD_SKIP, 3'h0, 8'h00, 8'h11);
      sk = (ops[i] == exec_pkg::OP_BIT_SKIP) ? !ms[i][3] : (ms[i] == 8'h00);
      w = (ops[i] == exec_pkg::OP_LOAD_SKIP) ? ms[i] : 8'h11;
      issue(ops[i], 3'h3, 8'h00, ms[i]);
      outs(1'b0, 1'b0, sk);
      chk(working_register, w);
      issue(exec_pkg::OP_XOR_IMM, 3'h0, 8'hff, 8'h00);
      chk(working_register, sk ? w : w ^ 8'hff);
      outs(1'b0, !sk, 1'b0);
    end
    $display("skip done");
  endtask

  task automatic t_rom();
    pc_page = 4'h3;
    rom_table_pointer = 8'h21;
    rom_rdata = 15'h5a6b;
    issue(exec_pkg::OP_ROM_CUR, 3'h0, 8'h00, 8'h00);
    chk(mem_wr, {1'b1, 8'h6b});
    chk(table_high_latch, 7'h5a);
    outs(1'b1, 1'b0, 1'b0);
    rom_rdata = 15'h13c4;
    issue(exec_pkg::OP_ROM_LAST, 3'h0, 8'h00, 8'h00);
    chk(mem_wr, {1'b1, 8'hc4});
    chk(table_high_latch, 7'h13);
    $display("rom done");
  endtask

  task automatic t_xor();
    issue(exec_pkg::OP_LOAD_SKIP, 3'h0, 8'h00, 8'h5a);
    issue(exec_pkg::OP_XOR_WORK, 3'h0, 8'h00, 8'h0f);
    chk(working_register, 8'h55);
    chk({zero_flag_we, zero_flag, mem_wr.we}, 3'b100);
    issue(exec_pkg::OP_XOR_MEM, 3'h0, 8'h00, 8'h55);
    chk(mem_wr, {1'b1, 8'h00});
    chk({working_register, zero_flag_we, zero_flag}, {8'h55, 2'b11});
    issue(exec_pkg::OP_XOR_IMM, 3'h0, 8'h55, 8'h00);
    chk({working_register, zero_flag_we, zero_flag, mem_wr.we}, {8'h00, 3'b110});
    $display("xor done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial
  begin
    failures = 0;
    compares = 0;
    rst = 1'b1;
    instr = '0;
    mem_rdata = 8'h00;
    rom_table_pointer = 8'h00;
    pc_page = 4'h0;
    rom_rdata = 15'h0000;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    chk({working_register, 1'b0, table_high_latch}, 16'h0000);
    outs(1'b0, 1'b0, 1'b0);
    $display("reset done");
    t_swap();
    t_skip();
    t_rom();
    t_xor();
    close_out();
  end
endmodule
